// [logic/rta_defs.svh]
// Constants for the alarm register block
// Notes on behaviour
// (R01) Weekly minute at 8h, bit 7 reads zero
// (R02) Weekly hour at 9h, bits 7:6 zero
// (R03) Weekly hour bit 5: meridiem or twenty
// (R04) Twelve-hour midnight is 12, noon 32
// (R05) Weekly day mask at Ah, bit 7 zero
// (R06) Day enable bit n selects weekday code n
// (R07) All-zero day mask suppresses weekly match
// (R08) Daily minute at Bh, bit 7 zero
// (R09) Daily hour at Ch, bits 7:6 zero
// (R10) Alarm contents undefined, upper bits read zero
// (R11) Match only when time equals alarm exactly
// (R12) Host never programs impossible alarm times
// (R13) Daily hour bit 5: meridiem or twenty
// (R14) Weekday counter steps 000 to 110, wraps
// (R15) Evaluate alarms once per minute rollover
// (R16) Writes to unimplemented bits are ignored
`ifndef RTA_DEFS_SVH
`define RTA_DEFS_SVH
`define RTA_OFS_WEEKDAY      4'h3
`define RTA_OFS_W_MINUTE     4'h8
`define RTA_OFS_W_HOUR       4'h9
`define RTA_OFS_W_DAY_MASK   4'ha
`define RTA_OFS_D_MINUTE     4'hb
`define RTA_OFS_D_HOUR       4'hc
`define RTA_MINUTE_MASK      8'h7f
`define RTA_HOUR_MASK        8'h3f
`define RTA_DAY_MASK_MASK    8'h7f
`define RTA_WEEKDAY_MASK     8'h07
`define RTA_WEEKDAY_LAST     3'h6
`define RTA_WEEKDAY_FIRST    3'h0
`define RTA_MERIDIEM_BIT     5
`define RTA_ALARM_RESET      8'h00
`define RTA_ZERO_BYTE        8'h00
`endif

// [logic/rta_pkg.sv]
// Types shared by the alarm register block
package rta_pkg;
  typedef logic [7:0] rta_byte_type;
  typedef logic [2:0] rta_weekday_type;
endpackage : rta_pkg

// [logic/rta_alarm_regs.sv]
// Alarm registers, weekday counter and minute-rollover alarm compare
`include "rta_defs.svh"
module rta_alarm_regs (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [3:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire rta_pkg::rta_byte_type     reg_wdata,
  output rta_pkg::rta_byte_type          reg_rd_data,
  input  wire logic                      day_carry,
  input  wire logic                      minute_tick,
  input  wire logic [6:0]                cur_minute,
  input  wire logic [5:0]                cur_hour,
  output rta_pkg::rta_weekday_type       weekday,
  output logic                           weekly_match,
  output logic                           daily_match
);

  rta_pkg::rta_byte_type   weekly_alarm_minute;
  rta_pkg::rta_byte_type   weekly_alarm_hour;
  rta_pkg::rta_byte_type   weekly_alarm_day_mask;
  rta_pkg::rta_byte_type   daily_alarm_minute;
  rta_pkg::rta_byte_type   daily_alarm_hour;
  rta_pkg::rta_byte_type   next_rd_data;
  rta_pkg::rta_weekday_type next_weekday;
  logic                    weekly_time_eq;
  logic                    daily_time_eq;
  logic                    day_enabled;
  logic                    weekday_wr;

  // Register writes; upper bits masked so they stay zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      weekly_alarm_minute   <= `RTA_ALARM_RESET; // R10
      weekly_alarm_hour     <= `RTA_ALARM_RESET;
      weekly_alarm_day_mask <= `RTA_ALARM_RESET;
      daily_alarm_minute    <= `RTA_ALARM_RESET;
      daily_alarm_hour      <= `RTA_ALARM_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `RTA_OFS_W_MINUTE:   weekly_alarm_minute   <= reg_wdata & `RTA_MINUTE_MASK;   // R01 R16
        `RTA_OFS_W_HOUR:     weekly_alarm_hour     <= reg_wdata & `RTA_HOUR_MASK;     // R02 R03 R04 R16
        `RTA_OFS_W_DAY_MASK: weekly_alarm_day_mask <= reg_wdata & `RTA_DAY_MASK_MASK; // R05 R16
        `RTA_OFS_D_MINUTE:   daily_alarm_minute    <= reg_wdata & `RTA_MINUTE_MASK;   // R08 R16
        `RTA_OFS_D_HOUR:     daily_alarm_hour      <= reg_wdata & `RTA_HOUR_MASK;     // R09 R13 R16
        default: begin
        end
      endcase
    end
  end

  // Weekday counter, loadable by software, wraps after code 6
  assign weekday_wr = reg_wr && (reg_addr == `RTA_OFS_WEEKDAY);

  always_comb begin
    next_weekday = weekday;
    if (weekday_wr) begin
      next_weekday = 3'(reg_wdata & `RTA_WEEKDAY_MASK);
    end else if (day_carry) begin
      if (weekday >= `RTA_WEEKDAY_LAST) begin
        next_weekday = `RTA_WEEKDAY_FIRST; // R14
      end else begin
        next_weekday = weekday + 3'h1; // R14
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      weekday <= `RTA_WEEKDAY_FIRST;
    end else begin
      weekday <= next_weekday;
    end
  end

  // Read mux, registered; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `RTA_OFS_WEEKDAY:    next_rd_data = {5'h00, weekday};
      `RTA_OFS_W_MINUTE:   next_rd_data = weekly_alarm_minute & `RTA_MINUTE_MASK;     // R01
      `RTA_OFS_W_HOUR:     next_rd_data = weekly_alarm_hour & `RTA_HOUR_MASK;         // R02
      `RTA_OFS_W_DAY_MASK: next_rd_data = weekly_alarm_day_mask & `RTA_DAY_MASK_MASK; // R05
      `RTA_OFS_D_MINUTE:   next_rd_data = daily_alarm_minute & `RTA_MINUTE_MASK;      // R08
      `RTA_OFS_D_HOUR:     next_rd_data = daily_alarm_hour & `RTA_HOUR_MASK;          // R09
      default:             next_rd_data = `RTA_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= `RTA_ZERO_BYTE;
    end else begin
      reg_rd_data <= next_rd_data;
    end
  end

  // Compare; hour compared as raw code, so meridiem bit takes part
  assign weekly_time_eq = (cur_minute == weekly_alarm_minute[6:0])
                       && (cur_hour == weekly_alarm_hour[5:0]); // R11 R03 R04
  assign daily_time_eq  = (cur_minute == daily_alarm_minute[6:0])
                       && (cur_hour == daily_alarm_hour[5:0]);  // R11 R13
  // Code 7 selects no bit, an all-zero mask selects none
  assign day_enabled    = (weekday <= `RTA_WEEKDAY_LAST)
                       && weekly_alarm_day_mask[weekday];       // R06 R07

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      weekly_match <= 1'b0;
      daily_match  <= 1'b0;
    end else begin
      weekly_match <= minute_tick && weekly_time_eq && day_enabled; // R15
      daily_match  <= minute_tick && daily_time_eq;                 // R15
    end
  end

  // Checks
  AST_W_MIN_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R01
    (reg_wr && reg_addr == `RTA_OFS_W_MINUTE) ##1 (reg_addr == `RTA_OFS_W_MINUTE) |=>
      (reg_rd_data[7] == 1'h0 && reg_rd_data[6:0] == $past(reg_wdata[6:0], 2)))
    else $error("weekly minute readback wrong");

  AST_W_HOUR_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R02
    (reg_wr && reg_addr == `RTA_OFS_W_HOUR) ##1 (reg_addr == `RTA_OFS_W_HOUR) |=>
      (reg_rd_data[7:6] == 2'h0 && reg_rd_data[5:0] == $past(reg_wdata[5:0], 2)))
    else $error("weekly hour readback wrong");

  AST_W_MASK_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R05
    (reg_wr && reg_addr == `RTA_OFS_W_DAY_MASK) ##1 (reg_addr == `RTA_OFS_W_DAY_MASK) |=>
      (reg_rd_data == ($past(reg_wdata, 2) & `RTA_DAY_MASK_MASK)))
    else $error("weekly day mask readback wrong");

  AST_D_MIN_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R08
    (reg_wr && reg_addr == `RTA_OFS_D_MINUTE) ##1 (reg_addr == `RTA_OFS_D_MINUTE) |=>
      (reg_rd_data == ($past(reg_wdata, 2) & `RTA_MINUTE_MASK)))
    else $error("daily minute readback wrong");

  AST_D_HOUR_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R09
    (reg_wr && reg_addr == `RTA_OFS_D_HOUR) ##1 (reg_addr == `RTA_OFS_D_HOUR) |=>
      (reg_rd_data == ($past(reg_wdata, 2) & `RTA_HOUR_MASK)))
    else $error("daily hour readback wrong");

  AST_UPPER_BITS_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R10 R16
    (reg_addr == `RTA_OFS_W_HOUR || reg_addr == `RTA_OFS_D_HOUR) |=> reg_rd_data[7:6] == 2'h0)
    else $error("unimplemented hour bits not zero");

  AST_REG_TOP_BITS: assert property (@(posedge sys_clk) disable iff (rst) // R10 R16
    weekly_alarm_minute[7] == 1'h0 && weekly_alarm_hour[7:6] == 2'h0 && weekly_alarm_day_mask[7] == 1'h0
      && daily_alarm_minute[7] == 1'h0 && daily_alarm_hour[7:6] == 2'h0)
    else $error("unimplemented alarm bit held a one");

  AST_REGS_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R16
    !(reg_wr && reg_addr inside {`RTA_OFS_W_MINUTE, `RTA_OFS_W_HOUR, `RTA_OFS_W_DAY_MASK,
      `RTA_OFS_D_MINUTE, `RTA_OFS_D_HOUR}) |=> $stable(weekly_alarm_minute) && $stable(weekly_alarm_hour)
      && $stable(weekly_alarm_day_mask) && $stable(daily_alarm_minute) && $stable(daily_alarm_hour))
    else $error("alarm register changed without a write to it");

  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // R16
    !(reg_addr inside {`RTA_OFS_WEEKDAY, `RTA_OFS_W_MINUTE, `RTA_OFS_W_HOUR, `RTA_OFS_W_DAY_MASK,
      `RTA_OFS_D_MINUTE, `RTA_OFS_D_HOUR}) |=> reg_rd_data == `RTA_ZERO_BYTE)
    else $error("unmapped offset read nonzero");

  AST_W_HOUR_BIT5: assert property (@(posedge sys_clk) disable iff (rst) // R03 R04
    (reg_wr && reg_addr == `RTA_OFS_W_HOUR) |=>
      weekly_alarm_hour[`RTA_MERIDIEM_BIT] == $past(reg_wdata[`RTA_MERIDIEM_BIT]))
    else $error("weekly hour bit 5 not kept");

  AST_D_HOUR_BIT5: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (reg_wr && reg_addr == `RTA_OFS_D_HOUR) |=>
      daily_alarm_hour[`RTA_MERIDIEM_BIT] == $past(reg_wdata[`RTA_MERIDIEM_BIT]))
    else $error("daily hour bit 5 not kept");

  AST_NO_MASK_NO_MATCH: assert property (@(posedge sys_clk) disable iff (rst) // R07
    (weekly_alarm_day_mask == `RTA_ZERO_BYTE) |=> !weekly_match)
    else $error("weekly match with empty day mask");

  AST_WEEKLY_CAUSE: assert property (@(posedge sys_clk) disable iff (rst) // R06 R11 R15
    weekly_match |-> $past(minute_tick) && $past(weekly_time_eq)
      && $past(weekly_alarm_day_mask[weekday]))
    else $error("weekly match without its cause");

  AST_WEEKLY_EXACT: assert property (@(posedge sys_clk) disable iff (rst) // R06 R11 R15
    (minute_tick && cur_minute == weekly_alarm_minute[6:0] && cur_hour == weekly_alarm_hour[5:0]
      && weekday <= `RTA_WEEKDAY_LAST && weekly_alarm_day_mask[weekday]) |=> weekly_match)
    else $error("weekly alarm missed");

  AST_WEEKLY_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // R03 R04 R11
    (!minute_tick || cur_minute != weekly_alarm_minute[6:0] || cur_hour != weekly_alarm_hour[5:0])
      |=> !weekly_match)
    else $error("weekly match on mismatch");

  AST_WEEKDAY_SEVEN_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // R06
    (weekday > `RTA_WEEKDAY_LAST) |=> !weekly_match)
    else $error("weekly match on weekday code 7");

  AST_DAILY_EXACT: assert property (@(posedge sys_clk) disable iff (rst) // R11 R13 R15
    (minute_tick && cur_minute == daily_alarm_minute[6:0] && cur_hour == daily_alarm_hour[5:0])
      |=> daily_match)
    else $error("daily alarm missed");

  AST_DAILY_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (!minute_tick || cur_hour != daily_alarm_hour[5:0]) |=> !daily_match)
    else $error("daily match on mismatch");

  AST_DAILY_MIN_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (cur_minute != daily_alarm_minute[6:0]) |=> !daily_match)
    else $error("daily match on minute mismatch");

  AST_NO_TICK_NO_MATCH: assert property (@(posedge sys_clk) disable iff (rst) // R15
    !minute_tick |=> !weekly_match && !daily_match)
    else $error("match without a minute rollover");

  AST_WEEKDAY_WRAP: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (day_carry && !weekday_wr && weekday == `RTA_WEEKDAY_LAST) |=> weekday == `RTA_WEEKDAY_FIRST)
    else $error("weekday did not wrap");

  AST_WEEKDAY_RANGE: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (day_carry && !weekday_wr && weekday < `RTA_WEEKDAY_LAST) |=> weekday == $past(weekday) + 3'h1)
    else $error("weekday did not step");

  AST_WEEKDAY_LOAD: assert property (@(posedge sys_clk) disable iff (rst) // R14
    weekday_wr |=> weekday == $past(reg_wdata[2:0]))
    else $error("weekday write not loaded");

  AST_WEEKDAY_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (!weekday_wr && !day_carry) |=> $stable(weekday))
    else $error("weekday moved without carry or write");

  AST_WEEKDAY_READ: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (reg_addr == `RTA_OFS_WEEKDAY) |=> reg_rd_data == {5'h00, $past(weekday)})
    else $error("weekday readback wrong");

  COV_WEEKLY_FIRES: cover property (@(posedge sys_clk) disable iff (rst) weekly_match);
  COV_WEEKDAY_STEPS: cover property (@(posedge sys_clk) disable iff (rst)
    day_carry && weekday < `RTA_WEEKDAY_LAST);
  COV_DAILY_FIRES: cover property (@(posedge sys_clk) disable iff (rst) daily_match);
  COV_WEEKDAY_WRAPS: cover property (@(posedge sys_clk) disable iff (rst)
    day_carry && weekday == `RTA_WEEKDAY_LAST);
  COV_BOTH_FIRE: cover property (@(posedge sys_clk) disable iff (rst) weekly_match && daily_match);

endmodule : rta_alarm_regs

// [test/rta_time_src.sv]
// Time-counter model feeding the alarm compare
module rta_time_src (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic       carry,
  input  wire logic [6:0] set_minute,
  input  wire logic [5:0] set_hour,
  output logic            minute_tick,
  output logic            day_carry,
  output logic [6:0]      cur_minute,
  output logic [5:0]      cur_hour
);
  timeunit 1ns;
  timeprecision 1ps;
  // New time lands together with its tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      minute_tick <= 1'b0;
      day_carry   <= 1'b0;
      cur_minute  <= 7'h00;
      cur_hour    <= 6'h12;
    end else begin
      minute_tick <= fire;
      day_carry   <= carry;
      if (fire) begin
        cur_minute <= set_minute;
        cur_hour   <= set_hour;
      end
    end
  end
endmodule : rta_time_src

// [test/rta_alarm_regs_tb_top.sv]
// Self-checking bench for the alarm registers
module rta_alarm_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, fire = 1'b0, carry = 1'b0;
  logic                     minute_tick, day_carry, weekly_match, daily_match;
  logic [3:0]               reg_addr = 4'h0;
  logic [6:0]               set_minute = 7'h00, cur_minute;
  logic [5:0]               set_hour = 6'h00, cur_hour;
  rta_pkg::rta_byte_type    reg_wdata = 8'h00, reg_rd_data;
  rta_pkg::rta_weekday_type weekday;
  int                       err_total = 0, cmp_count = 0;
  logic [3:0]               offs [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  logic [7:0]               msks [6] = '{8'h7f, 8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h00};
  rta_alarm_regs uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd_data(reg_rd_data), .day_carry(day_carry), .minute_tick(minute_tick), .cur_minute(cur_minute),
    .cur_hour(cur_hour), .weekday(weekday), .weekly_match(weekly_match), .daily_match(daily_match));
  rta_time_src far (.sys_clk(sys_clk), .rst(rst), .fire(fire), .carry(carry), .set_minute(set_minute),
    .set_hour(set_hour), .minute_tick(minute_tick), .day_carry(day_carry), .cur_minute(cur_minute),
    .cur_hour(cur_hour));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    chk(reg_rd_data, exp);
  endtask : rdc
  // Present a new minute and check both match pulses two edges later
  task automatic tick(input logic [6:0] m, input logic [5:0] h, input logic w, input logic d);
    @(negedge sys_clk);
    fire = 1'b1;
    set_minute = m;
    set_hour = h;
    @(negedge sys_clk);
    fire = 1'b0;
    @(negedge sys_clk);
    chk({7'h00, weekly_match}, {7'h00, w});
    chk({7'h00, daily_match}, {7'h00, d});
  endtask : tick
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    #100us;
    err_total++;
    $display("CHECK FAILED at %0t: timeout", $time);
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rdc(offs[i], 8'h00);
      wr(offs[i], 8'hff);
      rdc(offs[i], msks[i]);
    end
    $display("test registers done");
    wr(4'h8, 8'h30);
    wr(4'h9, 8'h32);
    wr(4'hb, 8'h30);
    wr(4'hc, 8'h12);
    for (int n = 0; n < 7; n++) begin
      wr(4'h3, 8'(n));
      wr(4'ha, 8'h01 << n);
      tick(7'h30, 6'h32, 1'b1, 1'b0);
      wr(4'ha, 8'h7f ^ (8'h01 << n));
      tick(7'h30, 6'h32, 1'b0, 1'b0);
    end
    tick(7'h30, 6'h12, 1'b0, 1'b1);
    tick(7'h31, 6'h12, 1'b0, 1'b0);
    wr(4'ha, 8'h00);
    tick(7'h30, 6'h32, 1'b0, 1'b0);
    $display("test alarms done");
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      carry = 1'b1;
      @(negedge sys_clk);
      carry = 1'b0;
      @(negedge sys_clk);
      chk({5'h00, weekday}, 8'(k));
    end
    rdc(4'h3, 8'h01);
    wr(4'h3, 8'hff);
    rdc(4'h3, 8'h07);
    wr(4'ha, 8'h7f);
    tick(7'h30, 6'h32, 1'b0, 1'b0);
    $display("test weekday done");
    conclude();
  end
endmodule : rta_alarm_regs_tb_top
